// ==== aogc_params.svh ====
// Behaviour
// - result = (raw - offset) x gain x amp gain
// - unipolar: negatives to zero, extra x2
// - self offset: short inputs, store raw
// - self gain: reference in, gain = 1/(raw-offset)
// - self calibrations run automatically, values reused
// - host keeps calibration conversion rate later
// - system cal: host applies inputs, device stores
// - host runs offset before gain calibration
// - offset is two's complement, resets zero
// - gain Q1.23 unsigned, resets to one
// - host avoids gain values below one half; aogc_host forwards any gain write unchecked
// - result changes only on conversion completion
// - 24-bit bipolar internal path and corrections
// - unipolar straight binary, bipolar two's complement
`ifndef AOGC_PARAMS_SVH
`define AOGC_PARAMS_SVH

`define AOGC_OFFSET_RST 24'h000000
`define AOGC_GAIN_RST 24'h800000
`define AOGC_GAIN_MAX 24'hFFFFFF
`define AOGC_MODE_RST 3'h0
`define AOGC_GAIN_FRAC 23
`define AOGC_OUT_DROP 8
`define AOGC_UNI_BOOST 1
`define AOGC_DIV_LAST 6'h2E
`define AOGC_SEL_OFFSET 2'h0
`define AOGC_SEL_GAIN 2'h1
`define AOGC_SEL_MODE 2'h2
`define AOGC_MODE_UNI_BIT 2
`define AOGC_UNI_MAX 53'sh0FFFF
`define AOGC_BIP_MAX 53'sh07FFF
`define AOGC_BIP_MIN (-53'sh08000)

`endif

// ==== aogc_pkg.sv ====
package aogc_pkg;

    typedef enum logic [2:0] {
        AOGC_CAL_NONE = 3'h0,
        AOGC_CAL_SELF_OFF = 3'h1,
        AOGC_CAL_SELF_GAIN = 3'h2,
        AOGC_CAL_SYS_OFF = 3'h3,
        AOGC_CAL_SYS_GAIN = 3'h4
    } aogc_cal_e;

    typedef enum logic [1:0] {
        AOGC_IN_NORMAL = 2'h0,
        AOGC_IN_SHORT = 2'h1,
        AOGC_IN_REF = 2'h2
    } aogc_in_e;

    typedef enum logic [2:0] {
        AOGC_DEV_IDLE = 3'b001,
        AOGC_DEV_WAIT = 3'b010,
        AOGC_DEV_DIV = 3'b100
    } aogc_dev_state_e;

    typedef enum logic [4:0] {
        AOGC_HOST_IDLE = 5'b00001,
        AOGC_HOST_OFF_REQ = 5'b00010,
        AOGC_HOST_OFF_RUN = 5'b00100,
        AOGC_HOST_GAIN_REQ = 5'b01000,
        AOGC_HOST_GAIN_RUN = 5'b10000
    } aogc_host_state_e;

endpackage : aogc_pkg

// ==== aogc_if.sv ====
interface aogc_if;
    logic wr;
    logic [1:0] sel;
    logic [23:0] wdata;
    aogc_pkg::aogc_cal_e cal_op;
    logic [23:0] offset_q;
    logic [23:0] gain_q;
    logic [2:0] mode_q;
    logic [15:0] result;
    logic result_valid;
    logic cal_busy;

    modport dev (
        input wr, sel, wdata, cal_op,
        output offset_q, gain_q, mode_q, result, result_valid, cal_busy
    );
    modport host (
        output wr, sel, wdata, cal_op,
        input offset_q, gain_q, mode_q, result, result_valid, cal_busy
    );
endinterface : aogc_if

// ==== aogc_dev.sv ====
`include "aogc_params.svh"

module aogc_dev (
    input wire logic clk_i,
    input wire logic rst_i,
    aogc_if.dev bus,
    input wire logic [23:0] raw_i,
    input wire logic raw_valid_i,
    output aogc_pkg::aogc_in_e in_sel_o
);

    // signed 24-bit in, 16-bit coded result out
    function automatic logic [15:0] aogc_correct(input logic [23:0] raw, input logic [23:0] offs,
                                                  input logic [23:0] gain, input logic [2:0] mode);
        logic signed [24:0] diff;
        logic signed [49:0] prod;
        logic signed [52:0] scaled;
        logic signed [52:0] code;
        logic [15:0] res;
        diff = $signed({raw[23], raw}) - $signed({offs[23], offs});
        prod = diff * $signed({1'b0, gain});
        scaled = $signed({{3{prod[49]}}, prod}) <<< mode[1:0];
        if (mode[`AOGC_MODE_UNI_BIT]) begin
            code = scaled >>> (`AOGC_GAIN_FRAC + `AOGC_OUT_DROP - `AOGC_UNI_BOOST);
            if (code < 0) begin
                res = 16'h0000;
            end else if (code > `AOGC_UNI_MAX) begin
                res = 16'hFFFF;
            end else begin
                res = code[15:0];
            end
        end else begin
            code = scaled >>> (`AOGC_GAIN_FRAC + `AOGC_OUT_DROP);
            if (code > `AOGC_BIP_MAX) begin
                res = 16'h7FFF;
            end else if (code < `AOGC_BIP_MIN) begin
                res = 16'h8000;
            end else begin
                res = code[15:0];
            end
        end
        return res;
    endfunction : aogc_correct

    aogc_pkg::aogc_dev_state_e state;
    aogc_pkg::aogc_dev_state_e next_state;
    aogc_pkg::aogc_cal_e op;
    aogc_pkg::aogc_cal_e next_op;
    aogc_pkg::aogc_in_e in_sel;
    aogc_pkg::aogc_in_e next_in_sel;
    logic [23:0] offset;
    logic [23:0] next_offset;
    logic [23:0] gain;
    logic [23:0] next_gain;
    logic [2:0] mode;
    logic [2:0] next_mode;
    logic [15:0] result;
    logic [15:0] next_result;
    logic result_valid;
    logic next_result_valid;
    logic [23:0] divisor;
    logic [23:0] next_divisor;
    logic [24:0] rem;
    logic [24:0] next_rem;
    logic [46:0] quot;
    logic [46:0] next_quot;
    logic [5:0] cnt;
    logic [5:0] next_cnt;

    always_comb begin
        logic signed [24:0] diff;
        logic [24:0] rem_sh;
        diff = 25'sh0000000;
        rem_sh = 25'h0000000;
        next_state = state;
        next_op = op;
        next_in_sel = in_sel;
        next_offset = offset;
        next_gain = gain;
        next_mode = mode;
        next_result = result;
        next_result_valid = 1'b0;
        next_divisor = divisor;
        next_rem = rem;
        next_quot = quot;
        next_cnt = cnt;
        unique case (state)
            aogc_pkg::AOGC_DEV_IDLE: begin
                if (bus.wr) begin
                    if (bus.sel == `AOGC_SEL_OFFSET) begin
                        next_offset = bus.wdata;
                    end else if (bus.sel == `AOGC_SEL_GAIN) begin
                        next_gain = bus.wdata;
                    end else if (bus.sel == `AOGC_SEL_MODE) begin
                        next_mode = bus.wdata[2:0];
                    end
                end
                if (bus.cal_op != aogc_pkg::AOGC_CAL_NONE) begin
                    next_op = bus.cal_op;
                    next_state = aogc_pkg::AOGC_DEV_WAIT;
                    if (bus.cal_op == aogc_pkg::AOGC_CAL_SELF_OFF) begin
                        next_in_sel = aogc_pkg::AOGC_IN_SHORT;
                    end else if (bus.cal_op == aogc_pkg::AOGC_CAL_SELF_GAIN) begin
                        next_in_sel = aogc_pkg::AOGC_IN_REF;
                    end else begin
                        next_in_sel = aogc_pkg::AOGC_IN_NORMAL;
                    end
                end else if (raw_valid_i) begin
                    next_result = aogc_correct(raw_i, offset, gain, mode);
                    next_result_valid = 1'b1;
                end
            end
            aogc_pkg::AOGC_DEV_WAIT: begin
                if (raw_valid_i) begin
                    next_in_sel = aogc_pkg::AOGC_IN_NORMAL;
                    if (op == aogc_pkg::AOGC_CAL_SELF_OFF || op == aogc_pkg::AOGC_CAL_SYS_OFF) begin
                        next_offset = raw_i;
                        next_state = aogc_pkg::AOGC_DEV_IDLE;
                    end else begin
                        diff = $signed({raw_i[23], raw_i}) - $signed({offset[23], offset});
                        if (diff <= 0 || diff[24:23] != 2'b00) begin
                            // no usable span sets the largest gain, a span of 8388608 or more sets gain 000001
                            next_gain = (diff <= 0) ? `AOGC_GAIN_MAX : 24'h000001;
                            next_state = aogc_pkg::AOGC_DEV_IDLE;
                        end else begin
                            next_divisor = diff[23:0];
                            next_rem = 25'h0000000;
                            next_quot = 47'h000000000000;
                            next_cnt = 6'h00;
                            next_state = aogc_pkg::AOGC_DEV_DIV;
                        end
                    end
                end
            end
            aogc_pkg::AOGC_DEV_DIV: begin
                // restoring division of 2^46 by the span, one quotient bit per cycle
                rem_sh = {rem[23:0], (cnt == 6'h00)};
                if (rem_sh >= {1'b0, divisor}) begin
                    next_rem = rem_sh - {1'b0, divisor};
                    next_quot = {quot[45:0], 1'b1};
                end else begin
                    next_rem = rem_sh;
                    next_quot = {quot[45:0], 1'b0};
                end
                next_cnt = cnt + 6'h01;
                if (cnt == `AOGC_DIV_LAST) begin
                    next_gain = (next_quot[46:24] != 23'h000000) ? `AOGC_GAIN_MAX : next_quot[23:0];
                    next_state = aogc_pkg::AOGC_DEV_IDLE;
                end
            end
            default: begin
                next_state = aogc_pkg::AOGC_DEV_IDLE;
                next_in_sel = aogc_pkg::AOGC_IN_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= aogc_pkg::AOGC_DEV_IDLE;
            op <= aogc_pkg::AOGC_CAL_NONE;
            in_sel <= aogc_pkg::AOGC_IN_NORMAL;
            offset <= `AOGC_OFFSET_RST;
            gain <= `AOGC_GAIN_RST;
            mode <= `AOGC_MODE_RST;
            result <= 16'h0000;
            result_valid <= 1'b0;
            divisor <= 24'h000000;
            rem <= 25'h0000000;
            quot <= 47'h000000000000;
            cnt <= 6'h00;
        end else begin
            state <= next_state;
            op <= next_op;
            in_sel <= next_in_sel;
            offset <= next_offset;
            gain <= next_gain;
            mode <= next_mode;
            result <= next_result;
            result_valid <= next_result_valid;
            divisor <= next_divisor;
            rem <= next_rem;
            quot <= next_quot;
            cnt <= next_cnt;
        end
    end

    assign bus.offset_q = offset;
    assign bus.gain_q = gain;
    assign bus.mode_q = mode;
    assign bus.result = result;
    assign bus.result_valid = result_valid;
    assign bus.cal_busy = (state != aogc_pkg::AOGC_DEV_IDLE);
    assign in_sel_o = in_sel;

endmodule : aogc_dev

// ==== aogc_host.sv ====
`include "aogc_params.svh"

module aogc_host (
    input wire logic clk_i,
    input wire logic rst_i,
    aogc_if.host bus,
    input wire logic usr_wr_i,
    input wire logic [1:0] usr_sel_i,
    input wire logic [23:0] usr_wdata_i,
    input wire logic usr_self_cal_i,
    input wire logic usr_sys_cal_i,
    input wire logic usr_input_ok_i,
    output logic usr_apply_zero_o,
    output logic usr_apply_fs_o,
    output logic usr_busy_o,
    output logic [15:0] usr_result_o,
    output logic usr_result_valid_o,
    output logic [23:0] usr_offset_o,
    output logic [23:0] usr_gain_o
);

    aogc_pkg::aogc_host_state_e state;
    aogc_pkg::aogc_host_state_e next_state;
    logic sys;
    logic next_sys;
    logic wr;
    logic next_wr;
    logic [1:0] sel;
    logic [1:0] next_sel;
    logic [23:0] wdata;
    logic [23:0] next_wdata;
    aogc_pkg::aogc_cal_e cal_op;
    aogc_pkg::aogc_cal_e next_cal_op;
    logic [15:0] result;
    logic [15:0] next_result;
    logic result_valid;
    logic next_result_valid;
    logic run_done;

    // a step is over once its start has gone and the device is idle again
    assign run_done = (cal_op == aogc_pkg::AOGC_CAL_NONE) && !bus.cal_busy;

    always_comb begin
        next_state = state;
        next_sys = sys;
        next_wr = 1'b0;
        next_sel = sel;
        next_wdata = wdata;
        next_cal_op = aogc_pkg::AOGC_CAL_NONE;
        next_result = bus.result_valid ? bus.result : result;
        next_result_valid = bus.result_valid;
        unique case (state)
            aogc_pkg::AOGC_HOST_IDLE: begin
                if (usr_self_cal_i || usr_sys_cal_i) begin
                    next_sys = usr_sys_cal_i;
                    next_state = aogc_pkg::AOGC_HOST_OFF_REQ;
                end else if (usr_wr_i) begin
                    next_wr = 1'b1;
                    next_sel = usr_sel_i;
                    next_wdata = usr_wdata_i;
                end
            end
            aogc_pkg::AOGC_HOST_OFF_REQ: begin
                if (!sys || usr_input_ok_i) begin
                    next_cal_op = sys ? aogc_pkg::AOGC_CAL_SYS_OFF : aogc_pkg::AOGC_CAL_SELF_OFF;
                    next_state = aogc_pkg::AOGC_HOST_OFF_RUN;
                end
            end
            aogc_pkg::AOGC_HOST_OFF_RUN: begin
                if (run_done) begin
                    next_state = aogc_pkg::AOGC_HOST_GAIN_REQ;
                end
            end
            aogc_pkg::AOGC_HOST_GAIN_REQ: begin
                if (!sys || usr_input_ok_i) begin
                    next_cal_op = sys ? aogc_pkg::AOGC_CAL_SYS_GAIN : aogc_pkg::AOGC_CAL_SELF_GAIN;
                    next_state = aogc_pkg::AOGC_HOST_GAIN_RUN;
                end
            end
            aogc_pkg::AOGC_HOST_GAIN_RUN: begin
                if (run_done) begin
                    next_state = aogc_pkg::AOGC_HOST_IDLE;
                end
            end
            default: begin
                next_state = aogc_pkg::AOGC_HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= aogc_pkg::AOGC_HOST_IDLE;
            sys <= 1'b0;
            wr <= 1'b0;
            sel <= `AOGC_SEL_OFFSET;
            wdata <= 24'h000000;
            cal_op <= aogc_pkg::AOGC_CAL_NONE;
            result <= 16'h0000;
            result_valid <= 1'b0;
        end else begin
            state <= next_state;
            sys <= next_sys;
            wr <= next_wr;
            sel <= next_sel;
            wdata <= next_wdata;
            cal_op <= next_cal_op;
            result <= next_result;
            result_valid <= next_result_valid;
        end
    end

    assign bus.wr = wr;
    assign bus.sel = sel;
    assign bus.wdata = wdata;
    assign bus.cal_op = cal_op;
    assign usr_apply_zero_o = sys && (state == aogc_pkg::AOGC_HOST_OFF_REQ || state == aogc_pkg::AOGC_HOST_OFF_RUN);
    assign usr_apply_fs_o = sys && (state == aogc_pkg::AOGC_HOST_GAIN_REQ || state == aogc_pkg::AOGC_HOST_GAIN_RUN);
    assign usr_busy_o = (state != aogc_pkg::AOGC_HOST_IDLE);
    assign usr_result_o = result;
    assign usr_result_valid_o = result_valid;
    assign usr_offset_o = bus.offset_q;
    assign usr_gain_o = bus.gain_q;

endmodule : aogc_host

// ==== aogc_chk.sv ====
module aogc_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr,
    input wire logic [1:0] sel,
    input wire logic [23:0] wdata,
    input wire aogc_pkg::aogc_cal_e cal_op,
    input wire logic [23:0] offset_q,
    input wire logic [23:0] gain_q,
    input wire logic [2:0] mode_q,
    input wire logic [15:0] result,
    input wire logic result_valid,
    input wire logic cal_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_offset_write: assert property (wr && sel == 2'h0 && !cal_busy |=> offset_q == $past(wdata))
        else $error("offset write lost");
    a_gain_write: assert property (wr && sel == 2'h1 && !cal_busy |=> gain_q == $past(wdata))
        else $error("gain write lost");
    a_mode_write: assert property (wr && sel == 2'h2 && !cal_busy |=> {21'h0, mode_q} == ($past(wdata) & 24'h000007))
        else $error("mode write lost");
    a_offset_cause: assert property ($changed(offset_q) |-> $past(wr) || $past(cal_busy))
        else $error("offset changed without cause");
    a_gain_cause: assert property ($changed(gain_q) |-> $past(wr) || $past(cal_busy))
        else $error("gain changed without cause");
    a_result_hold: assert property (!result_valid |-> $stable(result))
        else $error("result moved without conversion");
    a_cal_start: assert property (cal_op != aogc_pkg::AOGC_CAL_NONE && !cal_busy |=> cal_busy)
        else $error("calibration not started");
    a_cal_bound: assert property ($rose(cal_busy) |-> ##[1:300] !cal_busy)
        else $error("calibration hangs");
    a_cal_no_result: assert property (cal_busy |=> !result_valid)
        else $error("result during calibration");
    c_conv: cover property (result_valid);
    c_cal_done: cover property ($fell(cal_busy));
    c_mode_write: cover property (wr && sel == 2'h2);
endmodule : aogc_chk

// ==== testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic usr_wr_i = 1'b0;
    logic [1:0] usr_sel_i = 2'h0;
    logic [23:0] usr_wdata_i = 24'h000000;
    logic self_cal = 1'b0;
    logic sys_cal = 1'b0;
    logic input_ok = 1'b0;
    logic [23:0] raw_i = 24'h000000;
    logic raw_valid_i = 1'b0;
    logic zero_o, fs_o, busy, res_v;
    logic [15:0] res;
    logic [23:0] off_o, gain_o;
    aogc_pkg::aogc_in_e in_sel;
    logic [15:0] exp_q[$];
    logic [23:0] off = 24'h000000;
    logic [23:0] gn = 24'h800000;
    logic [2:0] md = 3'h0;
    logic [15:0] last = 16'h0000;
    int err_total = 0;
    int total_checks = 0;
    always #25 clk_i = ~clk_i;
    aogc_if ifc();
    aogc_dev aogc_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(ifc), .raw_i(raw_i), .raw_valid_i(raw_valid_i),
        .in_sel_o(in_sel));
    aogc_host aogc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(ifc), .usr_wr_i(usr_wr_i), .usr_sel_i(usr_sel_i),
        .usr_wdata_i(usr_wdata_i), .usr_self_cal_i(self_cal), .usr_sys_cal_i(sys_cal), .usr_input_ok_i(input_ok),
        .usr_apply_zero_o(zero_o), .usr_apply_fs_o(fs_o), .usr_busy_o(busy), .usr_result_o(res),
        .usr_result_valid_o(res_v), .usr_offset_o(off_o), .usr_gain_o(gain_o));
    aogc_chk aogc_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wr(ifc.wr), .sel(ifc.sel), .wdata(ifc.wdata),
        .cal_op(ifc.cal_op), .offset_q(ifc.offset_q), .gain_q(ifc.gain_q), .mode_q(ifc.mode_q),
        .result(ifc.result), .result_valid(ifc.result_valid), .cal_busy(ifc.cal_busy));
    function automatic logic [15:0] model(input logic [23:0] r);
        longint p;
        p = (longint'($signed(r)) - longint'($signed(off))) * longint'(gn);
        p = p <<< md[1:0];
        if (md[2]) begin
            p = p >>> 30;
            return (p < 0) ? 16'h0000 : (p > 65535) ? 16'hFFFF : p[15:0];
        end
        p = p >>> 31;
        return (p < -32768) ? 16'h8000 : (p > 32767) ? 16'h7FFF : p[15:0];
    endfunction : model
    task automatic fail(input string m);
        err_total++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : fail
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) fail($sformatf("result %h want %h", g, e));
    endtask : chk16
    task automatic chk24(input logic [23:0] g, input logic [23:0] e);
        total_checks++;
        if (g !== e) fail($sformatf("register %h want %h", g, e));
    endtask : chk24
    always @(posedge clk_i) begin
        if (res_v === 1'b1) begin
            if (exp_q.size() == 0) fail("extra result");
            else chk16(res, exp_q.pop_front());
        end
    end
    task automatic wt(input int k);
        int n;
        n = 0;
        while (!(k == 0 ? in_sel == aogc_pkg::AOGC_IN_SHORT : k == 1 ? in_sel == aogc_pkg::AOGC_IN_REF :
                k == 2 ? busy === 1'b0 : k == 3 ? ifc.cal_busy && zero_o : ifc.cal_busy && fs_o)) begin
            @(posedge clk_i);
            n++;
            if (n > 400) begin
                fail("wait timeout");
                stop_test();
            end
        end
    endtask : wt
    task automatic wreg(input logic [1:0] s, input logic [23:0] d);
        @(posedge clk_i);
        usr_wr_i <= 1'b1;
        usr_sel_i <= s;
        usr_wdata_i <= d;
        @(posedge clk_i);
        usr_wr_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        if (s == 2'h0) off = d;
        if (s == 2'h1) gn = d;
        if (s == 2'h2) md = d[2:0];
        chk24({21'h0, ifc.mode_q}, {21'h0, md});
        chk16(res, last);
    endtask : wreg
    task automatic conv(input int n, input logic [23:0] r0);
        logic [23:0] r;
        for (int i = 0; i < n; i++) begin
            r = (i == 0) ? r0 : 24'($urandom);
            @(posedge clk_i);
            raw_i <= r;
            raw_valid_i <= 1'b1;
            last = model(r);
            exp_q.push_back(last);
        end
        @(posedge clk_i);
        raw_valid_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        if (exp_q.size() != 0) fail("missing result");
    endtask : conv
    task automatic pulse(input logic [23:0] v);
        raw_i <= v;
        raw_valid_i <= 1'b1;
        @(posedge clk_i);
        raw_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask : pulse
    task automatic cal(input logic sys, input logic [23:0] zv, input logic [23:0] fv);
        longint d;
        longint q;
        @(posedge clk_i);
        self_cal <= !sys;
        sys_cal <= sys;
        input_ok <= sys;
        @(posedge clk_i);
        self_cal <= 1'b0;
        sys_cal <= 1'b0;
        wt(sys ? 3 : 0);
        pulse(zv);
        wt(sys ? 4 : 1);
        pulse(fv);
        wt(2);
        input_ok <= 1'b0;
        off = zv;
        d = longint'($signed(fv)) - longint'($signed(zv));
        q = (d > 0) ? (longint'(1) <<< 46) / d : 0;
        gn = (d <= 0) ? 24'hFFFFFF : (d >= 8388608) ? 24'h000001 : (q > 16777215) ? 24'hFFFFFF : q[23:0];
        chk24(off_o, off);
        chk24(gain_o, gn);
        conv(4, zv);
        $display("test calibration done");
    endtask : cal
    initial begin
        void'($urandom(16));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk24(off_o, 24'h000000);
        chk24(gain_o, 24'h800000);
        chk16(res, 16'h0000);
        $display("test reset done");
        for (int m = 0; m < 8; m++) begin
            wreg(2'h2, 24'(m));
            conv(6, m[0] ? 24'h7FFFFF : 24'h800000);
        end
        $display("test modes done");
        repeat (4) begin
            wreg(2'h0, 24'($urandom));
            wreg(2'h1, 24'h400000 + 24'($urandom_range(0, 24'hBFFFFF)));
            chk24(off_o, off);
            chk24(gain_o, gn);
            wreg(2'h2, 24'($urandom_range(0, 7)));
            wreg(2'h3, 24'h000005);
            conv(8, 24'h000000);
        end
        $display("test writes done");
        cal(1'b0, 24'($urandom) & 24'h000FFF, 24'h600000 + (24'($urandom) & 24'h0FFFFF));
        cal(1'b1, 24'hFFF000, 24'h7FFFFF);
        cal(1'b1, 24'h001000, 24'h000800);
        stop_test();
    end
endmodule : testbench
